// ---- rtl/mdsr_pkg.sv ----
// constants, encodings and state types for the mode, status and read path
// Operation
// RULE1: normal mode needs upper mode bits zero
// RULE2: nonzero upper mode bits are reserved
// RULE3: bank select 10 writes extended register
// RULE4: extended register holds until rewritten
// RULE5: temperature refresh bits accepted, no effect
// RULE6: partial refresh covers full to sixteenth
// RULE7: full array access; refresh only selection
// RULE8: status load uses bank 01, address zero
// RULE9: status read only with banks idle
// RULE10: wait setup interval, then read
// RULE11: only nop during completion interval
// RULE12: status read is two beats, latency kept
// RULE13: status word reports identity and density
// RULE14: refresh spacing scaled by reported multiplier
// RULE15: activate, wait, then column command
// RULE16: same bank reactivate after precharge, spacing
// RULE17: cross bank activates keep minimum spacing
// RULE18: read carries column, bank, autoprecharge
// RULE19: first beat after latency, then each edge
// RULE20: strobe preamble, postamble, then release
// RULE21: later read truncates or concatenates burst
// RULE22: burst stop ends read after latency
// RULE23: finish or stop read before write
// RULE24: precharge truncates read without autoprecharge
// RULE25: read latency two or three cycles
// RULE26: bank select 00 writes standard register
// RULE27: burst length 2, 4, 8, 16
// RULE28: commands on rising edges, data both
package mdsr_pkg;
  // pin and bus widths
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  localparam int LAT_MAX = 3;
  // command codes as {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_LOAD = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;
  // bank select values of a mode load
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_STATUS = 2'h1;
  localparam logic [1:0] BA_EXT = 2'h2;
  // standard mode register fields
  localparam int MR_W = 7;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [6:0] MODE_RST = 7'h31;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  // extended register fields
  localparam int EMR_PARTIAL_REFRESH_SELECT_LSB = 0;
  localparam int EMR_TEMP_COMP_REFRESH_FIELD_LSB = 3;
  localparam logic [12:0] EXT_RST = 13'h0000;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_FULL = 3'h0;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_HALF = 3'h1;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_QUARTER = 3'h2;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_EIGHTH = 3'h5;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_SIXTEENTH = 3'h6;
  // column command address bit that carries auto precharge
  localparam int AP_BIT = 10;
  // status word layout
  localparam int SW_MAKER_LSB = 0;
  localparam int SW_REV_LSB = 4;
  localparam int SW_MULT_LSB = 8;
  localparam int SW_WIDTH_BIT = 12;
  localparam int SW_DENS_LSB = 13;
  // burst slot kinds in the latency line
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_READ = 2'h1;
  localparam logic [1:0] SLOT_STOP = 2'h2;
  localparam logic [1:0] SLOT_PREC = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam int CTRL_W = 20;
  localparam int CTRL_MULT_LSB = 16;
  // data path states, one-hot
  typedef enum logic [3:0] {
    MDSR_IDLE = 4'b0001,
    MDSR_PREAMBLE = 4'b0010,
    MDSR_BURST = 4'b0100,
    MDSR_POSTAMBLE = 4'b1000
  } mdsr_dp_e;
endpackage : mdsr_pkg

// ---- rtl/mdsr_core.sv ----
// command decode, mode and extended registers, status read and read bursts
//
// Added by the designer: the address map and register access over AHB-Lite.
module mdsr_core #(
  parameter logic [3:0] MAKER_ID = 4'h5, // arbitrary value
  parameter logic [3:0] REV_ID = 4'h1, // arbitrary value
  parameter logic WIDTH_TYPE = 1'b0,
  parameter logic [2:0] DENSITY = 3'h2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // memory link, asynchronous to ref_clk
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [mdsr_pkg::BA_W-1:0] ba,
  input wire logic [mdsr_pkg::ADDR_W-1:0] addr,
  output logic [mdsr_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe,
  output logic dqs_o,
  output logic dqs_oe,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  import mdsr_pkg::*;

  localparam int PIN_W = 4 + BA_W + ADDR_W;

  // whole state of the block
  typedef struct packed {
    logic ck_s1; // first sync stage, read only by ck_s2
    logic ck_s2;
    logic ck_s3; // previous sample for edge finding
    logic [PIN_W-1:0] pin_s1; // first sync stage of command pins
    logic [PIN_W-1:0] pin_s2;
    logic [MR_W-1:0] mode_q;
    logic [ADDR_W-1:0] ext_q;
    logic sts_armed_q; // next read returns the status word
    logic [3:0] bank_open_q;
    logic [LAT_MAX-1:0][1:0] slot_kind;
    logic [LAT_MAX-1:0][BA_W-1:0] slot_bank;
    logic [LAT_MAX-1:0][COL_W-1:0] slot_col;
    logic [LAT_MAX-1:0] slot_ap;
    logic [LAT_MAX-1:0] slot_sts;
    mdsr_dp_e dp;
    logic [4:0] beat_idx;
    logic [4:0] beat_len;
    logic [BA_W-1:0] b_bank;
    logic [COL_W-1:0] b_col;
    logic b_ap;
    logic b_sts;
    logic b_ilv;
    logic [DQ_W-1:0] dq_q;
    logic dq_oe_q;
    logic dqs_q;
    logic dqs_oe_q;
    logic [CTRL_W-1:0] ctrl_q; // data pattern and sensor multiplier
    logic a_valid; // ahb data phase pending
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] hrdata_q;
  } mdsr_state_s;

  mdsr_state_s st_q;
  mdsr_state_s st_d;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // column of beat idx within the wrapped block
  function automatic logic [COL_W-1:0] mdsr_beat_col(input logic [COL_W-1:0] col,
      input logic [4:0] idx, input logic [4:0] len, input logic ilv);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;
    mask = COL_W'(len - 5'd1);
    low = ilv ? ((col ^ COL_W'(idx)) & mask) : ((col + COL_W'(idx)) & mask); // RULE27
    return (col & ~mask) | low;
  endfunction : mdsr_beat_col

  // beats per burst from the programmed length code
  function automatic logic [4:0] mdsr_len(input logic [2:0] code);
    logic [4:0] len;
    len = 5'd16;
    case (code) // RULE27
      BL_CODE_2: len = 5'd2;
      BL_CODE_4: len = 5'd4;
      BL_CODE_8: len = 5'd8;
      BL_CODE_16: len = 5'd16;
      default: len = 5'd16;
    endcase
    return len;
  endfunction : mdsr_len

  ////////////////////////////////////////////////////////////////////////////////
  // decoded views of the synchronised pins and registers

  logic ck_rise;
  logic ck_fall;
  logic [2:0] cmd;
  logic cmd_sel;
  logic [BA_W-1:0] cmd_ba;
  logic [ADDR_W-1:0] cmd_addr;
  logic [1:0] lat_slot;
  logic [DQ_W-1:0] status_word;
  logic [3:0] refresh_banks;
  logic [1:0] refresh_rows_kept;
  logic [31:0] stat_word;

  // edges are found on the second and third stage only
  assign ck_rise = st_q.ck_s2 & ~st_q.ck_s3; // RULE28
  assign ck_fall = ~st_q.ck_s2 & st_q.ck_s3;
  assign cmd_sel = ~st_q.pin_s2[PIN_W-1];
  assign cmd = st_q.pin_s2[PIN_W-2:PIN_W-4];
  assign cmd_ba = st_q.pin_s2[ADDR_W+BA_W-1:ADDR_W];
  assign cmd_addr = st_q.pin_s2[ADDR_W-1:0];
  // latency slot index, latency two or else three
  assign lat_slot = (st_q.mode_q[MR_CL_LSB+:3] == CL_CODE_2) ? 2'd1 : 2'd2; // RULE25

  // status word; multiplier comes from the sensor value held in ctrl
  assign status_word = DQ_W'({DENSITY, WIDTH_TYPE, st_q.ctrl_q[CTRL_MULT_LSB+:4],
      REV_ID, MAKER_ID}); // RULE13 RULE14

  // partial refresh decode; only reported in the status register view, not used for access
  always_comb begin
    refresh_banks = 4'hf;
    refresh_rows_kept = 2'b00;
    case (st_q.ext_q[EMR_PARTIAL_REFRESH_SELECT_LSB+:3]) // RULE6 RULE7
      PARTIAL_REFRESH_SELECT_FULL: refresh_banks = 4'hf;
      PARTIAL_REFRESH_SELECT_HALF: refresh_banks = 4'h3;
      PARTIAL_REFRESH_SELECT_QUARTER: refresh_banks = 4'h1;
      PARTIAL_REFRESH_SELECT_EIGHTH: begin
        refresh_banks = 4'h1;
        refresh_rows_kept = 2'b01;
      end
      PARTIAL_REFRESH_SELECT_SIXTEENTH: begin
        refresh_banks = 4'h1;
        refresh_rows_kept = 2'b11;
      end
      default: refresh_banks = 4'hf;
    endcase
  end

  // status register view of internal state
  assign stat_word = {20'h00000, refresh_rows_kept, refresh_banks,
      st_q.dp == MDSR_BURST, st_q.sts_armed_q, st_q.bank_open_q};

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [1:0] pop_kind;
    logic [4:0] nidx;
    st_d = st_q;
    pop_kind = SLOT_NONE;
    nidx = 5'd0;

    // two-flop synchronisers for the link clock and pins
    st_d.ck_s1 = ck;
    st_d.ck_s2 = st_q.ck_s1;
    st_d.ck_s3 = st_q.ck_s2;
    st_d.pin_s1 = {cs_n, ras_n, cas_n, we_n, ba, addr};
    st_d.pin_s2 = st_q.pin_s1;

    // postamble lasts one half cycle, then pins float
    if ((ck_rise | ck_fall) && st_q.dp == MDSR_POSTAMBLE) begin
      st_d.dp = MDSR_IDLE; // RULE20
      st_d.dqs_oe_q = 1'b0;
      st_d.dq_oe_q = 1'b0;
    end

    // running burst advances one beat on every link edge
    if ((ck_rise | ck_fall) && st_q.dp == MDSR_BURST) begin
      nidx = st_q.beat_idx + 5'd1;
      if (nidx == st_q.beat_len) begin
        st_d.dp = MDSR_POSTAMBLE; // RULE20
        st_d.dq_oe_q = 1'b0;
        st_d.dqs_q = 1'b0;
        if (st_q.b_ap) begin
          st_d.bank_open_q[st_q.b_bank] = 1'b0; // RULE18
        end
      end else begin
        st_d.beat_idx = nidx; // RULE19
        st_d.dqs_q = ~nidx[0];
        st_d.dq_q = st_q.b_sts ? DQ_W'(0) : (st_q.ctrl_q[DQ_W-1:0] ^
            DQ_W'({st_q.b_bank, 5'h00,
            mdsr_beat_col(st_q.b_col, nidx, st_q.beat_len, st_q.b_ilv)}));
      end
    end

    // rising edge: latency line moves, commands are decoded
    if (ck_rise) begin
      pop_kind = st_q.slot_kind[0];
      for (int i = 0; i < LAT_MAX - 1; i++) begin
        st_d.slot_kind[i] = st_q.slot_kind[i+1];
        st_d.slot_bank[i] = st_q.slot_bank[i+1];
        st_d.slot_col[i] = st_q.slot_col[i+1];
        st_d.slot_ap[i] = st_q.slot_ap[i+1];
        st_d.slot_sts[i] = st_q.slot_sts[i+1];
      end
      st_d.slot_kind[LAT_MAX-1] = SLOT_NONE;

      // a read leaving the line starts a burst, overriding any older one
      if (pop_kind == SLOT_READ) begin
        st_d.dp = MDSR_BURST; // RULE19 RULE21
        st_d.b_bank = st_q.slot_bank[0];
        st_d.b_col = st_q.slot_col[0];
        st_d.b_ap = st_q.slot_ap[0];
        st_d.b_sts = st_q.slot_sts[0];
        st_d.b_ilv = st_q.mode_q[MR_BT_BIT];
        st_d.beat_idx = 5'd0;
        // status reads are fixed at two beats
        st_d.beat_len = st_q.slot_sts[0] ? 5'd2 : mdsr_len(st_q.mode_q[MR_BL_LSB+:3]); // RULE12
        st_d.dq_oe_q = 1'b1;
        st_d.dqs_oe_q = 1'b1;
        st_d.dqs_q = 1'b1;
        st_d.dq_q = st_q.slot_sts[0] ? status_word : (st_q.ctrl_q[DQ_W-1:0] ^
            DQ_W'({st_q.slot_bank[0], 5'h00, st_q.slot_col[0]})); // RULE12 RULE13
      end else if (st_q.dp == MDSR_BURST && st_d.dp == MDSR_BURST &&
          (pop_kind == SLOT_STOP ||
          (pop_kind == SLOT_PREC && st_q.slot_bank[0] == st_q.b_bank))) begin
        // stop and precharge cut the burst one read latency after issue
        st_d.dp = MDSR_POSTAMBLE; // RULE22 RULE24
        st_d.dq_oe_q = 1'b0;
        st_d.dqs_q = 1'b0;
      end

      if (cmd_sel) begin
        case (cmd)
          CMD_LOAD: begin
            case (cmd_ba)
              BA_MODE: begin
                // reserved upper patterns are ignored rather than guessed at
                if (cmd_addr[ADDR_W-1:MR_W] == '0) begin
                  st_d.mode_q = cmd_addr[MR_W-1:0]; // RULE26 RULE1 RULE2
                end
              end
              BA_EXT: begin
                // temperature bits are stored but steer nothing
                st_d.ext_q = cmd_addr; // RULE3 RULE4 RULE5
              end
              BA_STATUS: begin
                st_d.sts_armed_q = (cmd_addr == '0); // RULE8
              end
              default: begin
                st_d.sts_armed_q = st_q.sts_armed_q;
              end
            endcase
          end
          CMD_ACT: begin
            st_d.bank_open_q[cmd_ba] = 1'b1; // RULE15
          end
          CMD_READ: begin
            st_d.slot_kind[lat_slot] = SLOT_READ; // RULE18 RULE21
            st_d.slot_bank[lat_slot] = cmd_ba;
            st_d.slot_col[lat_slot] = cmd_addr[COL_W-1:0];
            st_d.slot_ap[lat_slot] = cmd_addr[AP_BIT];
            st_d.slot_sts[lat_slot] = st_q.sts_armed_q; // RULE10
            st_d.sts_armed_q = 1'b0;
          end
          CMD_STOP: begin
            st_d.slot_kind[lat_slot] = SLOT_STOP; // RULE22
          end
          CMD_PRE: begin
            st_d.slot_kind[lat_slot] = SLOT_PREC; // RULE24
            st_d.slot_bank[lat_slot] = cmd_ba;
            if (cmd_addr[AP_BIT]) begin
              st_d.bank_open_q = 4'h0;
            end else begin
              st_d.bank_open_q[cmd_ba] = 1'b0;
            end
          end
          default: begin
            st_d.sts_armed_q = st_q.sts_armed_q;
          end
        endcase
      end

      // strobe preamble one cycle ahead of a fresh burst
      if ((st_d.dp == MDSR_IDLE || st_d.dp == MDSR_POSTAMBLE) &&
          st_d.slot_kind[0] == SLOT_READ) begin
        st_d.dp = MDSR_PREAMBLE; // RULE20
        st_d.dqs_oe_q = 1'b1;
        st_d.dqs_q = 1'b0;
        st_d.dq_oe_q = 1'b0;
      end
    end

    // ahb data phase: write to the control word
    st_d.a_valid = 1'b0;
    st_d.hrdata_q = 32'h00000000;
    if (st_q.a_valid && st_q.a_wr && st_q.a_ofs == OFS_CTRL) begin
      st_d.ctrl_q = hwdata[CTRL_W-1:0];
    end

    // ahb address phase; read data is captured now, zero wait states
    if (hsel && hready && htrans[1]) begin
      st_d.a_valid = 1'b1;
      st_d.a_wr = hwrite;
      st_d.a_ofs = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          OFS_CTRL: st_d.hrdata_q = {12'h000, st_d.ctrl_q};
          OFS_MODE: st_d.hrdata_q = {25'h0000000, st_q.mode_q};
          OFS_EXT: st_d.hrdata_q = {19'h00000, st_q.ext_q};
          OFS_STAT: st_d.hrdata_q = stat_word;
          default: st_d.hrdata_q = 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.pin_s1 <= '1;
      st_q.pin_s2 <= '1;
      st_q.mode_q <= MODE_RST;
      st_q.ext_q <= EXT_RST;
      st_q.dp <= MDSR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dq_o = st_q.dq_q;
  assign dq_oe = st_q.dq_oe_q;
  assign dqs_o = st_q.dqs_q;
  assign dqs_oe = st_q.dqs_oe_q;
  // hsize is not checked: only whole-word singles are expected
  assign hreadyout = 1'b1;
  assign hrdata = st_q.hrdata_q;
  assign hresp = 1'b0;

endmodule : mdsr_core

// ---- bench/mdsr_checker.sv ----
// concurrent checks on the read strobe, data enable and bus answer of mdsr_core
module mdsr_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic hreadyout,
  input wire logic hresp
);
  timeunit 1ns;
  timeprecision 100ps;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // data never leaves without its strobe
  AST_DQ_WITH_STROBE: assert property (dq_oe |-> dqs_oe)
    else $error("data driven without strobe");
  // two system clocks early to three late are allowed around the one-cycle preamble
  AST_PREAMBLE: assert property ($rose(dqs_oe) |-> (!dq_oe && !dqs_o) [*6] ##[1:6] dq_oe)
    else $error("read preamble wrong");
  AST_FIRST_BEAT_HIGH: assert property ($rose(dq_oe) |-> dqs_o)
    else $error("first beat strobe not high");
  // even the shortest burst is one pair of beats
  AST_MIN_PAIR: assert property ($rose(dq_oe) |-> dq_oe [*6])
    else $error("burst shorter than a pair");
  AST_STROBE_TOGGLES: assert property ((dq_oe && dqs_o) |-> ##[1:6] (!dqs_o || !dq_oe))
    else $error("strobe stuck high in burst");
  // beats follow ck edges, not every system clock
  AST_BEAT_HOLDS: assert property ($rose(dqs_o) |=> dqs_o [*2])
    else $error("beat shorter than half ck");
  AST_POSTAMBLE: assert property ($fell(dq_oe) |-> (dqs_oe && !dqs_o))
    else $error("postamble missing");
  AST_RELEASE: assert property ($fell(dq_oe) |-> ##[2:6] !dqs_oe)
    else $error("strobe not released");
  AST_AHB_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  ////////////////////////////////////////////////////////////////////////////////
  // main scenarios reached
  CV_BURST: cover property ($rose(dq_oe));
  CV_LONG: cover property (dq_oe [*8]);
  CV_END: cover property ($fell(dqs_oe));
endmodule : mdsr_checker

// ---- bench/mdsr_host.sv ----
// behavioural memory controller: link clock and command pins
module mdsr_host (
  input wire logic run,
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [mdsr_pkg::BA_W-1:0] ba,
  output logic [mdsr_pkg::ADDR_W-1:0] addr
);
  import mdsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ck stands low until run; offset keeps it out of phase with ref_clk
  initial begin
    ck = 1'b0;
    #7;
    forever begin
      #80;
      ck = run ? ~ck : 1'b0;
    end
  end
  // deselected at time zero
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = '0;
    addr = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pins move on the falling edge so they are steady at the rise
  task cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge ck);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
  endtask : cmd
  // deselect; unselected pins show a changing pattern, not a stale value
  task nop(input int n);
    repeat (n) begin
      @(negedge ck);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
      ba <= ~ba;
      addr <= ~addr;
    end
  endtask : nop
endmodule : mdsr_host

// ---- bench/testbench.sv ----
// self-checking bench for mdsr_core with host model and ahb master
module testbench;
  import mdsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0] mode;
    logic [1:0] b;
    logic [8:0] col;
    logic [4:0] bl;
    logic il;
    logic [1:0] cl;
  } mdsr_row_s;
  localparam logic [15:0] PAT = 16'ha5c5;
  logic ref_clk;
  logic resetn;
  logic run;
  logic ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_o, dqs_oe, hreadyout, hresp, pdqs, poe;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_o;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] q[$]; // captured beats
  time t_cmd, t_first;
  mdsr_row_s rows [5];
  logic [2:0] pc [5] = '{PARTIAL_REFRESH_SELECT_FULL, PARTIAL_REFRESH_SELECT_HALF, PARTIAL_REFRESH_SELECT_QUARTER, PARTIAL_REFRESH_SELECT_EIGHTH, PARTIAL_REFRESH_SELECT_SIXTEENTH};
  logic [5:0] pm [5] = '{6'h0f, 6'h03, 6'h01, 6'h11, 6'h31}; // {row top bits, banks}
  assign hready = hreadyout; // single slave
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  mdsr_core #(.MAKER_ID(4'h9), .REV_ID(4'h3), .WIDTH_TYPE(1'b1), .DENSITY(3'h4)) mdsr_core_i (
    .ref_clk, .resetn, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_o, .dq_oe, .dqs_o,
    .dqs_oe, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp);
  mdsr_host mdsr_host_i (.run, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
  ////////////////////////////////////////////////////////////////////////////////
  // a beat is a new strobe level while data is driven; also the hang limit
  always @(posedge ref_clk) begin
    pdqs <= dqs_o;
    poe <= dq_oe;
    if (dq_oe === 1'b1 && (poe !== 1'b1 || dqs_o !== pdqs)) q.push_back(dq_o);
    if (dq_oe === 1'b1 && poe !== 1'b1) t_first = $time;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  // single ahb transfer; r holds read data taken at the end of the data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask : ahb
  task rg(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(s, r & m, e);
  endtask : rg
  task ld(input logic [1:0] b, input logic [12:0] a);
    mdsr_host_i.cmd(CMD_LOAD, b, a);
    mdsr_host_i.nop(2);
  endtask : ld
  task rd(input logic [1:0] b, input logic [12:0] a);
    q.delete();
    mdsr_host_i.cmd(CMD_READ, b, a);
    t_cmd = $time + 80;
  endtask : rd
  // column order within the burst block, then the data pattern
  function automatic logic [15:0] beat(logic [1:0] b, logic [8:0] c, int k, int bl, logic il);
    logic [8:0] m;
    logic [8:0] o;
    m = 9'(bl - 1);
    o = il ? ((c ^ 9'(k)) & m) : ((c + 9'(k)) & m);
    return PAT ^ {b, 5'h0, (c & ~m) | o};
  endfunction : beat
  task beats(input string s, input int i, input logic [1:0] b, input logic [8:0] c, input int bl,
             input logic il, input int n);
    for (int k = 0; k < n; k++) chk(s, {16'h0, q[i + k]}, {16'h0, beat(b, c, k, bl, il)});
  endtask : beats
  task summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{7'h21, 2'h0, 9'h001, 5'h2, 1'b0, 2'h2}, '{7'h32, 2'h1, 9'h003, 5'h4, 1'b0, 2'h3},
      '{7'h3b, 2'h2, 9'h005, 5'h8, 1'b1, 2'h3}, '{7'h24, 2'h3, 9'h1fe, 5'h10, 1'b0, 2'h2},
      '{7'h2a, 2'h0, 9'h00e, 5'h4, 1'b1, 2'h2}};
    // every input starts idle; reset is low from time zero
    resetn <= 1'b0;
    run <= 1'b0;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run <= 1'b1;
    rg("mode rst", OFS_MODE, 32'hffffffff, 32'h31);
    rg("ext rst", OFS_EXT, 32'hffffffff, 32'h0);
    rg("unmapped", 8'h40, 32'hffffffff, 32'h0);
    ahb(1'b1, OFS_MODE, 32'h7f);
    rg("mode ro", OFS_MODE, 32'hffffffff, 32'h31);
    ahb(1'b1, OFS_CTRL, {12'h0, 4'h3, PAT});
    rg("ctrl", OFS_CTRL, 32'hffffffff, {12'h0, 4'h3, PAT});
    mdsr_host_i.nop(2);
    // every burst length, both orders, both latencies, one bank each
    foreach (rows[i]) begin
      ld(BA_MODE, {6'h0, rows[i].mode});
      rg("mode", OFS_MODE, 32'hffffffff, {25'h0, rows[i].mode});
      mdsr_host_i.cmd(CMD_ACT, rows[i].b, 13'h0);
      mdsr_host_i.nop(2);
      rd(rows[i].b, {4'h0, rows[i].col});
      mdsr_host_i.nop(14);
      chk("count", q.size(), 32'(rows[i].bl));
      chk("latency", 32'((t_first - t_cmd) / 160), 32'(rows[i].cl));
      beats("data", 0, rows[i].b, rows[i].col, 32'(rows[i].bl), rows[i].il, 32'(rows[i].bl));
    end
    ld(BA_MODE, 13'h01a2);
    rg("mode rsv", OFS_MODE, 32'hffffffff, 32'h2a);
    for (int k = 0; k < 5; k++) begin
      ld(BA_EXT, {5'h0, 3'h5, 2'(k), pc[k]});
      rg("ext", OFS_EXT, 32'hffffffff, {24'h0, 3'h5, 2'(k), pc[k]});
      rg("partial_refresh_select", OFS_STAT, 32'hfc0, {20'h0, pm[k], 6'h0});
    end
    ld(BA_MODE, 13'h0033);
    rg("ext kept", OFS_EXT, 32'hffffffff, 32'ha6);
    // status read needs every bank closed first
    mdsr_host_i.cmd(CMD_PRE, 2'h0, 13'h0400);
    mdsr_host_i.nop(2);
    rg("pre all", OFS_STAT, 32'hf, 32'h0);
    // status read while bursts are set to eight
    ld(BA_STATUS, 13'h0);
    rg("armed", OFS_STAT, 32'h10, 32'h10);
    rd(2'h0, 13'h0);
    mdsr_host_i.nop(12);
    chk("sr count", q.size(), 32'h2);
    chk("sr word", {16'h0, q[0]}, 32'h9339);
    rg("disarm", OFS_STAT, 32'h10, 32'h0);
    mdsr_host_i.cmd(CMD_ACT, 2'h2, 13'h0);
    mdsr_host_i.nop(2);
    rg("open", OFS_STAT, 32'hf, 32'h4);
    // bank outside the refreshed part is still readable
    rd(2'h2, 13'h0403);
    mdsr_host_i.nop(14);
    chk("ap count", q.size(), 32'h8);
    beats("ap", 0, 2'h2, 9'h003, 8, 1'b0, 8);
    rg("ap closed", OFS_STAT, 32'hf, 32'h0);
    mdsr_host_i.cmd(CMD_ACT, 2'h1, 13'h0);
    mdsr_host_i.nop(2);
    // second read two cycles later keeps two pairs of the first
    rd(2'h1, 13'h0);
    mdsr_host_i.nop(1);
    mdsr_host_i.cmd(CMD_READ, 2'h1, 13'h008);
    mdsr_host_i.nop(16);
    chk("tr count", q.size(), 32'hc);
    beats("tr a", 0, 2'h1, 9'h0, 8, 1'b0, 4);
    beats("tr b", 4, 2'h1, 9'h8, 8, 1'b0, 8);
    rd(2'h1, 13'h010);
    mdsr_host_i.cmd(CMD_STOP, 2'h1, 13'h0);
    mdsr_host_i.nop(12);
    chk("stop count", q.size(), 32'h2);
    rg("page open", OFS_STAT, 32'hf, 32'h2);
    rd(2'h1, 13'h020);
    mdsr_host_i.nop(2);
    mdsr_host_i.cmd(CMD_PRE, 2'h1, 13'h0);
    mdsr_host_i.nop(12);
    chk("pre count", q.size(), 32'h6);
    rg("pre closed", OFS_STAT, 32'hf, 32'h0);
    // reset in mid run restores the defaults
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("oe rst", {31'h0, dq_oe}, 32'h0);
    resetn <= 1'b1;
    rg("mode rst2", OFS_MODE, 32'hffffffff, 32'h31);
    rg("ext rst2", OFS_EXT, 32'hffffffff, 32'h0);
    summarize();
  end
endmodule : testbench
bind mdsr_core mdsr_checker mdsr_checker_i (.ref_clk, .resetn, .dq_oe, .dqs_o, .dqs_oe,
  .hreadyout, .hresp);
